// ===== src/touch_conv_ctl.sv
/*
  Conversion control register and sequencer of a touch-screen converter.
  Assumes a host port that gives one-cycle write/read strobes with address,
  a converter result word from the analog core, and a synchronous pen input.
*/
`timescale 1ns/10ps
// Operation
// - Bit 15 routes pen irq or general irq
// - Decode three-bit manual channel field
// - Decode two-bit conversion mode field
// - Acquisition 4, 8, 16, 32 clock periods
// - Temperature uses fixed 16 us settling
// - Interval 550 us plus 35 us steps
// - Slave mode: timer starts after sequence
// - Master mode: restart timer while touched
// - Release stops timer; touch starts sequence
// - GPIO enabled skips aux and battery in slave and master sequences
// - Aux and battery selected: battery only
// - Clear mode at end when timer zero, in single and slave mode only
// - First-conversion delay per screen channel, end
module touch_conv_ctl #(
  parameter int FCD_CYCLES = touch_ctl_pkg::FCD_CYC,
  parameter int TMR_BASE   = touch_ctl_pkg::TMR_BASE_CYC,
  parameter int TMR_STEP   = touch_ctl_pkg::TMR_STEP_CYC
) (
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        gpio_enable_in,
  input  wire logic [5:0]  seq_channels_in,
  input  wire logic        pen_touch_in,
  input  wire logic        data_ready_in,
  input  wire logic [11:0] adc_result_in,
  output logic [15:0]      reg_rdata_out,
  output logic             pen_down_irq_out,
  output logic             general_irq_enable_out,
  output logic [2:0]       convert_channel_out,
  output logic             convert_start_out,
  output logic             sequence_busy_out,
  output logic [11:0]      result_out [8]
);
  if (FCD_CYCLES < 1 || TMR_BASE < 1 || TMR_STEP < 1)
  begin : g_bad_timing
    $error("touch_conv_ctl: timing parameters must be positive");
  end

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b00_0001,
    ST_FCD   = 6'b00_0010,
    ST_ACQ   = 6'b00_0100,
    ST_CONV  = 6'b00_1000,
    ST_END   = 6'b01_0000,
    ST_WAIT  = 6'b10_0000
  } seq_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_screen(input logic [2:0] ch);
    is_screen = ch[2];
  endfunction

  // Sequence bit i corresponds to channel code i+2 (battery..X plus)
  function automatic logic [5:0] filter_seq(input logic [5:0] sel, input logic gp);
    logic [5:0] s;
    s = sel;
    if (gp)
      s[1:0] = 2'b00;
    else if (s[0] && s[1])
      s[1] = 1'b0;
    filter_seq = s;
  endfunction

  logic [15:0] conv_ctrl;
  seq_state_t  state;
  logic [23:0] count;
  logic [7:0]  pending;
  logic [7:0]  avail;
  logic [2:0]  cur_ch;
  logic        pen_q;
  logic        seq_end;
  logic [1:0]  mode;
  logic [7:0]  tmr;
  logic [2:0]  next_ch;
  logic [23:0] acq_cyc;
  logic [23:0] wait_cyc;

  assign mode     = conv_ctrl[touch_ctl_pkg::POS_MODE_HI:touch_ctl_pkg::POS_MODE_LO];
  assign tmr      = conv_ctrl[touch_ctl_pkg::POS_TMR_HI:touch_ctl_pkg::POS_TMR_LO];
  assign seq_end  = (state == ST_END) && (count == 24'h00_0000);

  // Acquisition length in system cycles
  always_comb
  begin
    if (cur_ch == touch_ctl_pkg::CH_TEMP)
      acq_cyc = 24'(touch_ctl_pkg::TEMP_SETTLE_CYC);
    else
      acq_cyc = 24'((touch_ctl_pkg::ACQ_BASE_PER * touch_ctl_pkg::CONV_PER_CYC)
                << conv_ctrl[touch_ctl_pkg::POS_ACQ_HI:touch_ctl_pkg::POS_ACQ_LO]);
  end

  // Interval length: base plus step per code above one
  always_comb
  begin
    wait_cyc = 24'(TMR_BASE + (int'(tmr) - 1) * TMR_STEP);
  end

  // Highest pending channel first, skipping the one in conversion
  always_comb
  begin
    avail   = (state == ST_CONV) ? (pending & ~(8'h01 << cur_ch)) : pending;
    next_ch = touch_ctl_pkg::CH_NONE;
    for (int i = 0; i < 8; i++)
      if (avail[i])
        next_ch = 3'(i);
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      conv_ctrl <= touch_ctl_pkg::CONV_CTRL_RESET;
    else if (reg_wr_in && reg_addr_in == touch_ctl_pkg::ADDR_CONV_CTRL)
      conv_ctrl <= reg_wdata_in;
    else if (seq_end && tmr == 8'h00 &&
             (mode == touch_ctl_pkg::MODE_SINGLE || mode == touch_ctl_pkg::MODE_SLAVE))
      conv_ctrl[touch_ctl_pkg::POS_MODE_HI:touch_ctl_pkg::POS_MODE_LO]
        <= touch_ctl_pkg::MODE_IDLE;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= 16'h0000;
    else if (reg_rd_in && reg_addr_in == touch_ctl_pkg::ADDR_CONV_CTRL)
      reg_rdata_out <= conv_ctrl;
    else if (reg_rd_in && reg_addr_in[3])
      reg_rdata_out <= {4'h0, result_out[reg_addr_in[2:0]]};
    else if (reg_rd_in)
      reg_rdata_out <= 16'h0000;
  end

  // ----------------------------------------------------------------
  // Interrupt routing
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      pen_down_irq_out       <= 1'b0;
      general_irq_enable_out <= 1'b0;
      pen_q                  <= 1'b0;
    end
    else
    begin
      pen_down_irq_out       <= pen_touch_in && !conv_ctrl[touch_ctl_pkg::POS_PEN_DIS];
      general_irq_enable_out <= conv_ctrl[touch_ctl_pkg::POS_PEN_DIS];
      pen_q                  <= pen_touch_in;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      state             <= ST_IDLE;
      count             <= 24'h00_0000;
      pending           <= 8'h00;
      cur_ch            <= touch_ctl_pkg::CH_NONE;
      convert_start_out <= 1'b0;
      convert_channel_out <= touch_ctl_pkg::CH_NONE;
      sequence_busy_out <= 1'b0;
    end
    else
    begin
      convert_start_out <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (mode == touch_ctl_pkg::MODE_SINGLE &&
              conv_ctrl[touch_ctl_pkg::POS_CHAN_HI:touch_ctl_pkg::POS_CHAN_LO]
                != touch_ctl_pkg::CH_NONE)
          begin
            pending <= 8'h01 << conv_ctrl[touch_ctl_pkg::POS_CHAN_HI:touch_ctl_pkg::POS_CHAN_LO];
            state   <= ST_FCD;
            count   <= 24'(FCD_CYCLES);
            sequence_busy_out <= 1'b1;
          end
          else if (mode == touch_ctl_pkg::MODE_SLAVE ||
                   (mode == touch_ctl_pkg::MODE_MASTER && pen_touch_in && !pen_q))
          begin
            pending <= {filter_seq(seq_channels_in, gpio_enable_in), 2'b00};
            state   <= ST_FCD;
            count   <= 24'(FCD_CYCLES);
            sequence_busy_out <= 1'b1;
          end
        end
        ST_FCD:
        begin
          if (count != 24'h00_0000)
            count <= count - 24'h00_0001;
          else
          begin
            cur_ch <= next_ch;
            count  <= (next_ch == touch_ctl_pkg::CH_NONE) ? 24'(FCD_CYCLES) : 24'h00_0000;
            state  <= (next_ch == touch_ctl_pkg::CH_NONE) ? ST_END : ST_ACQ;
          end
        end
        ST_ACQ:
        begin
          if (count < acq_cyc)
            count <= count + 24'h00_0001;
          else
          begin
            convert_channel_out <= cur_ch;
            convert_start_out   <= 1'b1;
            count <= 24'(touch_ctl_pkg::CONV_CYC);
            state <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          if (count != 24'h00_0000)
            count <= count - 24'h00_0001;
          else
          begin
            pending[cur_ch] <= 1'b0;
            cur_ch          <= next_ch;
            if (next_ch == touch_ctl_pkg::CH_NONE || is_screen(next_ch))
            begin
              count <= 24'(FCD_CYCLES);
              state <= (next_ch == touch_ctl_pkg::CH_NONE) ? ST_END : ST_FCD;
            end
            else
            begin
              count <= 24'h00_0000;
              state <= ST_ACQ;
            end
          end
        end
        ST_END:
        begin
          if (count != 24'h00_0000)
            count <= count - 24'h00_0001;
          else if (tmr == 8'h00 || mode == touch_ctl_pkg::MODE_SINGLE ||
                   (mode == touch_ctl_pkg::MODE_MASTER && !pen_touch_in))
          begin
            state <= ST_IDLE;
            sequence_busy_out <= 1'b0;
          end
          else
          begin
            count <= wait_cyc;
            state <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (mode == touch_ctl_pkg::MODE_IDLE ||
              (mode == touch_ctl_pkg::MODE_MASTER && !pen_touch_in))
          begin
            state <= ST_IDLE;
            sequence_busy_out <= 1'b0;
          end
          else if (count != 24'h00_0000)
            count <= count - 24'h00_0001;
          else
          begin
            pending <= {filter_seq(seq_channels_in, gpio_enable_in), 2'b00};
            count <= 24'(FCD_CYCLES);
            state <= ST_FCD;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Result capture
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      for (int i = 0; i < 8; i++)
        result_out[i] <= 12'h000;
    end
    else if (data_ready_in)
      result_out[convert_channel_out] <= adc_result_in;
  end
endmodule // touch_conv_ctl

// ===== src/touch_ctl_pkg.sv
/*
  Constants for the touch-screen conversion control block: register map,
  field positions, channel and mode encodings, timing figures.
  Assumes a 10 MHz system clock.
*/
package touch_ctl_pkg;
  localparam int          CLK_HZ          = 10_000_000;
  localparam logic [3:0]  ADDR_CONV_CTRL  = 4'h1;
  localparam logic [15:0] CONV_CTRL_RESET = 16'h0000;
  localparam int          POS_PEN_DIS     = 15;
  localparam int          POS_CHAN_HI     = 14;
  localparam int          POS_CHAN_LO     = 12;
  localparam int          POS_MODE_HI     = 11;
  localparam int          POS_MODE_LO     = 10;
  localparam int          POS_ACQ_HI      = 9;
  localparam int          POS_ACQ_LO      = 8;
  localparam int          POS_TMR_HI      = 7;
  localparam int          POS_TMR_LO      = 0;
  localparam int          POS_GPIO_EN     = 13;
  // Channel codes
  localparam logic [2:0]  CH_XPLUS        = 3'h7;
  localparam logic [2:0]  CH_YPLUS        = 3'h6;
  localparam logic [2:0]  CH_PRESS_ONE    = 3'h5;
  localparam logic [2:0]  CH_PRESS_TWO    = 3'h4;
  localparam logic [2:0]  CH_AUX          = 3'h3;
  localparam logic [2:0]  CH_BATT         = 3'h2;
  localparam logic [2:0]  CH_TEMP         = 3'h1;
  localparam logic [2:0]  CH_NONE         = 3'h0;
  // Mode codes
  localparam logic [1:0]  MODE_IDLE       = 2'h0;
  localparam logic [1:0]  MODE_SINGLE     = 2'h1;
  localparam logic [1:0]  MODE_SLAVE      = 2'h2;
  localparam logic [1:0]  MODE_MASTER     = 2'h3;
  // Timing in converter clock periods (2 MHz nominal, 500 ns), microseconds and system cycles
  localparam int          ACQ_BASE_PER    = 4;
  localparam int          CONV_PER_NS     = 500;
  localparam int          CONV_PER_CYC    = CONV_PER_NS / (1_000_000_000 / CLK_HZ);
  localparam int          TEMP_SETTLE_US  = 16;
  localparam int          TEMP_SETTLE_CYC = TEMP_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int          TMR_BASE_US     = 550;
  localparam int          TMR_STEP_US     = 35;
  localparam int          TMR_BASE_CYC    = TMR_BASE_US * (CLK_HZ / 1_000_000);
  localparam int          TMR_STEP_CYC    = TMR_STEP_US * (CLK_HZ / 1_000_000);
  localparam int          CONV_US         = 8;
  localparam int          CONV_CYC        = CONV_US * (CLK_HZ / 1_000_000);
  localparam int          FCD_US          = 1024;
  localparam int          FCD_CYC         = FCD_US * (CLK_HZ / 1_000_000);
endpackage

// ===== test/touch_conv_ctl_sva.sv
/*
  Checker for the conversion control block, bound to its top ports.
  Assumes the bench runs the design with a shortened delay count.
*/
`timescale 1ns/10ps
module touch_conv_ctl_sva #(
  parameter int FCD_CYCLES = 20
) (
  input wire logic        sys_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        gpio_enable_in,
  input wire logic [5:0]  seq_channels_in,
  input wire logic        pen_touch_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        pen_down_irq_out,
  input wire logic        general_irq_enable_out,
  input wire logic [2:0]  convert_channel_out,
  input wire logic        convert_start_out,
  input wire logic        sequence_busy_out
);
  // ----------------------------------------
  // Helpers and properties
  // ----------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  int unsigned busy_cnt;
  int unsigned since_start;
  logic        pen_dis;
  always_ff @(posedge sys_clk_in)
  begin
    busy_cnt    <= (sys_rst_in || !sequence_busy_out) ? 0 : busy_cnt + 1;
    since_start <= (sys_rst_in || convert_start_out) ? 0 : since_start + 1;
    if (sys_rst_in)
      pen_dis <= 1'b0;
    else if (reg_wr_in && reg_addr_in == 4'h1)
      pen_dis <= reg_wdata_in[15];
  end
  irq_route_a: assert property ((reg_wr_in && reg_addr_in == 4'h1) ##1 !reg_wr_in [*2]
    |-> general_irq_enable_out == pen_dis) else $error("general irq enable wrong");
  irq_excl_a: assert property (pen_down_irq_out |-> !general_irq_enable_out
    && $past(pen_touch_in)) else $error("pen irq without cause");
  chan_valid_a: assert property (convert_start_out |-> convert_channel_out != 3'h0)
    else $error("conversion on no channel");
  start_pulse_a: assert property (convert_start_out |=> !convert_start_out)
    else $error("start longer than one cycle");
  start_busy_a: assert property (convert_start_out |-> sequence_busy_out)
    else $error("start outside sequence");
  first_delay_a: assert property (convert_start_out |-> busy_cnt >= FCD_CYCLES)
    else $error("first conversion delay short");
  end_delay_a: assert property ($fell(sequence_busy_out) |-> since_start >= FCD_CYCLES)
    else $error("final delay short");
  gpio_skip_a: assert property (gpio_enable_in && convert_start_out
    |-> convert_channel_out inside {[3'h4:3'h7], 3'h1}) else $error("aux or battery with gpio");
  aux_skip_a: assert property (seq_channels_in[0] && convert_start_out
    |-> convert_channel_out != 3'h3) else $error("aux converted with battery");
  unmapped_rd_a: assert property (reg_rd_in && reg_addr_in inside {4'h0, [4'h2:4'h7]}
    |=> reg_rdata_out == 16'h0000) else $error("unmapped read not zero");
  single_c: cover property (convert_start_out && convert_channel_out == 3'h1);
  touch_c: cover property ($rose(pen_touch_in) ##[1:3] $rose(sequence_busy_out));
  gpio_c: cover property (gpio_enable_in && convert_start_out);
endmodule // touch_conv_ctl_sva
bind touch_conv_ctl touch_conv_ctl_sva #(.FCD_CYCLES(FCD_CYCLES)) checker_i (
  .sys_clk_in             (sys_clk_in),
  .sys_rst_in             (sys_rst_in),
  .reg_wr_in              (reg_wr_in),
  .reg_rd_in              (reg_rd_in),
  .reg_addr_in            (reg_addr_in),
  .reg_wdata_in           (reg_wdata_in),
  .gpio_enable_in         (gpio_enable_in),
  .seq_channels_in        (seq_channels_in),
  .pen_touch_in           (pen_touch_in),
  .reg_rdata_out          (reg_rdata_out),
  .pen_down_irq_out       (pen_down_irq_out),
  .general_irq_enable_out (general_irq_enable_out),
  .convert_channel_out    (convert_channel_out),
  .convert_start_out      (convert_start_out),
  .sequence_busy_out      (sequence_busy_out)
);

// ===== test/touch_front_model.sv
/*
  Analog front end model: answers each start with a tagged result.
  Assumes start and channel come from the sequencer on the same clock.
*/
`timescale 1ns/10ps
module touch_front_model (
  input  wire logic       clk_in,
  input  wire logic       start_in,
  input  wire logic [2:0] channel_in,
  input  wire logic [3:0] delay_in,
  output logic            ready_out = 1'b0,
  output logic [11:0]     result_out = 12'h000
);
  logic [4:0] cnt = 5'h00;
  logic [2:0] ch_q = 3'h0;
  always @(posedge clk_in)
  begin
    ready_out <= 1'b0;
    result_out <= ~result_out;
    if (start_in)
    begin
      ch_q <= channel_in;
      cnt <= 5'(delay_in) + 5'h01;
    end
    else if (cnt == 5'h01)
    begin
      ready_out <= 1'b1;
      result_out <= {ch_q, 9'h0a5};
      cnt <= 5'h00;
    end
    else if (cnt != 5'h00)
      cnt <= cnt - 5'h01;
  end
endmodule // touch_front_model

// ===== test/testbench.sv
/*
  Self-checking bench for the conversion control block.
  Assumes the front end model answers every conversion start.
*/
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------
  // Stimulus, tasks and checks
  // ----------------------------------------
  logic sys_clk_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
  logic gpio_enable_in = 0, pen_touch_in = 0, data_ready_in;
  logic [3:0]  reg_addr_in = 0, dly = 0;
  logic [15:0] reg_wdata_in = 0, reg_rdata_out;
  logic [5:0]  seq_channels_in = 0;
  logic [11:0] adc_result_in, result_out [8];
  logic [2:0]  convert_channel_out;
  logic        pen_down_irq_out, general_irq_enable_out, convert_start_out, sequence_busy_out;
  logic [17:0] got = 0;
  int          n_fail = 0, checked = 0;
  touch_conv_ctl #(.FCD_CYCLES(20), .TMR_BASE(5), .TMR_STEP(2)) uut (.*);
  touch_front_model fe (.clk_in(sys_clk_in), .start_in(convert_start_out),
    .channel_in(convert_channel_out), .delay_in(dly), .ready_out(data_ready_in),
    .result_out(adc_result_in));
  always #50 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in)
    if (convert_start_out === 1'b1)
      got <= {got[14:0], convert_channel_out};
  task automatic test_done;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    reg_wr_in = 1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(posedge sys_clk_in) #1 reg_wr_in = 0;
    @(posedge sys_clk_in) #1;
  endtask
  task automatic wait_start(output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk_in) #1;
      n++;
    end
    while (convert_start_out !== 1'b1 && n < 2000);
    if (n == 2000)
    begin
      n_fail++;
      test_done();
    end
  endtask
  task automatic rreg(input logic [3:0] a, output logic [17:0] d);
    reg_rd_in = 1;
    reg_addr_in = a;
    @(posedge sys_clk_in) #1 reg_rd_in = 0;
    @(posedge sys_clk_in) #1 d = {2'h0, reg_rdata_out};
  endtask
  task automatic wait_lvl(input logic lvl, input int lim, input bit must, output int n);
    for (n = 0; sequence_busy_out !== lvl && n < lim; n++)
      @(posedge sys_clk_in) #1;
    if (must && n == lim)
    begin
      n_fail++;
      test_done();
    end
  endtask
  function automatic logic [17:0] data_of(input logic [2:0] c);
    return {6'h00, c, 9'h0a5};
  endfunction
  function automatic logic [17:0] order(input logic [5:0] s, input logic g);
    order = 0;
    for (int i = 5; i >= 0; i--)
      if (s[i] && !(i < 2 && g) && !(i == 1 && s[0]))
        order = {order[14:0], 3'(i + 2)};
  endfunction
  task automatic one_shot(input logic [2:0] c, input logic [1:0] a, output int n);
    logic [17:0] d;
    wreg(4'h1, {1'b0, c, touch_ctl_pkg::MODE_SINGLE, a, 8'h00});
    wait_lvl(1, 5, 1, n);
    wait_lvl(0, 2000, 1, n);
    chk(18'(result_out[c]), data_of(c));
    rreg(4'h1, d);
    chk(d, {3'h0, c, 2'h0, a, 8'h00});
  endtask
  task automatic run_seq(input logic [5:0] s, input logic g, input logic [1:0] a);
    logic [17:0] d;
    int          n;
    seq_channels_in = s;
    gpio_enable_in = g;
    dly = 4'($urandom);
    got = 0;
    wreg(4'h1, {6'h02, a, 8'h00});
    wait_lvl(1, 5, 1, n);
    wait_lvl(0, 5000, 1, n);
    chk(got, order(s, g));
    for (d = got; d != 0; d = d >> 3)
      chk(18'(result_out[d[2:0]]), data_of(d[2:0]));
    rreg(4'h1, d);
    chk(d, {8'h00, a, 8'h00});
    wait_lvl(1, 100, 0, n);
    chk(18'(n), 18'h64);
  endtask
  initial
  begin
    int          n, m;
    logic [17:0] d;
    logic [5:0]  s;
    logic        g;
    void'($urandom(34064));
    repeat (12) @(posedge sys_clk_in);
    #1 sys_rst_in = 0;
    rreg(4'h1, d);
    chk(d, 18'h0);
    rreg(4'h5, d);
    chk(d, 18'h0);
    for (int c = 1; c < 8; c += 6)
      for (int a = 0; a < 4; a++)
      begin
        one_shot(3'(c), 2'(a), n);
        if (a == 0)
          m = n;
        chk(18'(n - m), 18'(c == 1 ? 0 : ((4 << a) - 4) * 5));
      end
    for (int i = 0; i < 10; i++)
    begin
      s = 6'($urandom);
      g = 1'($urandom);
      if (i < 3)
        {s, g} = (i == 0) ? 7'h06 : (i == 1) ? 7'h07 : 7'h04;
      run_seq(s, g, 2'($urandom));
    end
    {seq_channels_in, gpio_enable_in} = 7'h40;
    for (int t = 1; t < 4; t += 2)
    begin
      wreg(4'h1, {6'h02, 2'h0, 8'(t)});
      wait_start(n);
      wait_start(n);
      rreg(4'h1, d);
      chk(d, {6'h02, 2'h0, 8'(t)});
      if (t == 1)
        m = n;
      else
        chk(18'(n - m), 18'h4);
      wreg(4'h1, 16'h0000);
      wait_lvl(0, 5000, 1, n);
    end
    wreg(4'h1, {6'h03, 2'h0, 8'h01});
    wait_lvl(1, 50, 0, n);
    chk(18'(n), 18'h32);
    pen_touch_in = 1;
    wait_lvl(1, 4, 1, n);
    chk({17'h0, pen_down_irq_out}, 18'h1);
    wait_start(n);
    wait_start(n);
    chk(18'(n - m), 18'h0);
    pen_touch_in = 0;
    wait_lvl(0, 5000, 1, n);
    wait_lvl(1, 100, 0, n);
    chk(18'(n), 18'h64);
    pen_touch_in = 1;
    wait_lvl(1, 4, 1, n);
    wreg(4'h1, 16'h8000);
    wait_lvl(0, 5000, 1, n);
    @(posedge sys_clk_in) #1;
    chk({16'h0, general_irq_enable_out, pen_down_irq_out}, 18'h2);
    test_done();
  end
endmodule // testbench
